//--- rtl/serial_status_flags.sv
// Purpose: Status flags of the serial unit and their set/clear events
// Assumes: Shifters and baud logic live outside; strobes are one cycle
// Notes: Register read is combinational, flags themselves are flops
`timescale 1ns/100ps

// Functional notes
// R1: Register resets to 84h, also in low power
// R2: Five flags cleared by read-1 then write-0
// R3: Transmit-done and received mp bit ignore writes
// R4: Tx empty sets on disable or buffer transfer
// R5: Tx empty clears on holding buffer write
// R6: Rx full sets on clean receive; read clears
// R7: Error or disabled: rx buffer, full unchanged
// R8: Overrun when char completes with full set
// R9: Overrun stalls reception; sync also transmit
// R10: Framing error on first stop bit zero
// R11: Framing error loads buffer, full stays clear
// R12: Framing stalls reception; sync also transmit
// R13: Parity mismatch sets parity flag, loads buffer
// R14: Parity stalls reception; sync also transmit
// R15: Receive disable keeps error and mp flags
// R16: Tx done sets on disable or last bit
// R17: Mp bit captured per received async character; code only with mp enabled and buffer empty
// R18: Mp bit to send used in async mp
// R19: Tx empty irq is flag and enable
// R20: Rx irqs follow flags and rx enable
// R21: Tx done irq is flag and enable
// R22: Clear needs read record, set wins
module serial_status_flags
    import serial_status_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_lp_mode,
    // CPU access
    input wire cpu_acc_t i_stat_acc,
    output logic [STAT_W-1:0] o_stat_rdata,
    input wire logic i_tx_buf_wr,
    input wire logic [DATA_W-1:0] i_tx_buf_wdata,
    input wire logic i_rx_buf_rd,
    output logic [DATA_W-1:0] o_rx_holding_buffer,
    // Control
    input wire logic i_transmit_enable,
    input wire logic i_rx_on,
    input wire logic i_async,
    input wire logic i_mp_enable,
    input wire logic i_parity_en,
    input wire logic i_parity_odd_select,
    input wire logic i_tx_irq_enable,
    input wire logic i_rx_irq_enable,
    input wire logic i_tx_done_irq_enable,
    // Transmit path
    input wire logic i_tx_load,
    input wire logic i_tx_last_bit,
    output logic [DATA_W-1:0] o_tx_holding_buffer,
    output logic o_tx_mp_bit,
    output logic o_tx_allowed,
    // Receive path
    input wire rx_char_t i_rx_char,
    output logic o_rx_allowed,
    // Interrupts
    output irq_t o_irq
);
    logic tx_empty;
    logic rx_full;
    logic overrun;
    logic framing;
    logic parity;
    logic tx_done_r;
    logic mp_rx_r;
    logic mp_tx_r;
    logic [DATA_W-1:0] rx_buf_r;
    logic [DATA_W-1:0] tx_buf_r;
    logic fer_now;
    logic per_now;
    logic err_any;
    logic rx_take;
    logic te_fall;
    logic tx_empty_clr_sw;
    logic tx_empty_clr;
    logic tx_empty_set;
    logic tx_done_set;
    logic tx_rd_seen_r;
    logic rx_full_set;
    logic overrun_set;
    logic framing_set;
    logic parity_set;
    logic mp_rx_take;

    // ****************************************
    // Receive character checks
    // ****************************************
    rx_char_check u_check (
        .i_char(i_rx_char),
        .i_async(i_async),
        .i_parity_en(i_parity_en),
        .i_parity_odd_select(i_parity_odd_select),
        .o_framing(fer_now),
        .o_parity(per_now)
    );

    assign err_any = overrun || framing || parity;
    // Any error flag halts reception; sync mode halts transmit too
    assign o_rx_allowed = i_rx_on && !err_any; // [R9] [R12] [R14]
    assign o_tx_allowed = i_async || !err_any; // [R9] [R12] [R14]
    // Disabled receiver ignores completions entirely
    assign rx_take = i_rx_char.done && o_rx_allowed; // [R7] [R15]

    // ****************************************
    // Transmit enable level
    // ****************************************
    // Level low keeps it pinned at 1 rather than an edge only
    assign te_fall = !i_transmit_enable;

    // ****************************************
    // Set events
    // ****************************************
    assign tx_empty_set = te_fall || i_tx_load; // [R4]
    assign tx_done_set = te_fall || (i_tx_last_bit && tx_empty); // [R16]
    // Framing and parity errors only count while no clean character waits in the buffer
    assign rx_full_set = rx_take && !rx_full && !fer_now && !per_now;
    assign overrun_set = rx_take && rx_full; // [R8]
    assign framing_set = rx_take && !rx_full && fer_now; // [R10]
    assign parity_set = rx_take && !rx_full && per_now; // [R13]
    assign mp_rx_take = rx_take && i_async && i_mp_enable && !rx_full;

    // ****************************************
    // Flags
    // ****************************************
    assign tx_empty_clr_sw = i_stat_acc.wr && !i_stat_acc.wdata[B_TX_EMPTY];

    clear_by_write_flag #(.RESET_VAL(STAT_RESET[B_TX_EMPTY])) u_tx_empty (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_lp_reset(i_lp_mode), // [R1]
        .i_set(tx_empty_set), // [R4]
        .i_hw_clr(i_tx_buf_wr), // [R5]
        .i_rd(i_stat_acc.rd),
        .i_wr(i_stat_acc.wr),
        .i_wbit(i_stat_acc.wdata[B_TX_EMPTY]),
        .o_flag(tx_empty)
    );

    clear_by_write_flag #(.RESET_VAL(STAT_RESET[B_RX_FULL])) u_rx_full (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_lp_reset(i_lp_mode),
        .i_set(rx_full_set), // [R6] [R11]
        .i_hw_clr(i_rx_buf_rd), // [R6]
        .i_rd(i_stat_acc.rd),
        .i_wr(i_stat_acc.wr),
        .i_wbit(i_stat_acc.wdata[B_RX_FULL]),
        .o_flag(rx_full)
    );

    clear_by_write_flag #(.RESET_VAL(STAT_RESET[B_OVERRUN])) u_overrun (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_lp_reset(i_lp_mode),
        .i_set(overrun_set), // [R8]
        .i_hw_clr(1'b0),
        .i_rd(i_stat_acc.rd),
        .i_wr(i_stat_acc.wr),
        .i_wbit(i_stat_acc.wdata[B_OVERRUN]),
        .o_flag(overrun)
    );

    clear_by_write_flag #(.RESET_VAL(STAT_RESET[B_FRAMING])) u_framing (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_lp_reset(i_lp_mode),
        .i_set(framing_set), // [R10]
        .i_hw_clr(1'b0),
        .i_rd(i_stat_acc.rd),
        .i_wr(i_stat_acc.wr),
        .i_wbit(i_stat_acc.wdata[B_FRAMING]),
        .o_flag(framing)
    );

    clear_by_write_flag #(.RESET_VAL(STAT_RESET[B_PARITY])) u_parity (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_lp_reset(i_lp_mode),
        .i_set(parity_set), // [R13]
        .i_hw_clr(1'b0),
        .i_rd(i_stat_acc.rd),
        .i_wr(i_stat_acc.wr),
        .i_wbit(i_stat_acc.wdata[B_PARITY]),
        .o_flag(parity)
    );

    // Mirror of the tx empty read record; without it a bare write of 0
    // would drop tx done while tx empty stays set
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            tx_rd_seen_r <= 1'b0;
        else if (i_lp_mode || i_stat_acc.wr || !tx_empty)
            tx_rd_seen_r <= 1'b0;
        else if (i_stat_acc.rd)
            tx_rd_seen_r <= 1'b1; // [R22]
    end

    // Tx done follows the same clears as tx empty, set wins
    assign tx_empty_clr = !tx_empty_set && (i_tx_buf_wr ||
        (tx_empty_clr_sw && tx_rd_seen_r && tx_empty)); // [R16]

    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            tx_done_r <= STAT_RESET[B_TX_DONE]; // [R1]
        else if (i_lp_mode)
            tx_done_r <= STAT_RESET[B_TX_DONE];
        else if (tx_done_set)
            tx_done_r <= 1'b1; // [R16]
        else if (tx_empty_clr)
            tx_done_r <= 1'b0; // [R16] [R3]
    end

    // ****************************************
    // Multiprocessor bits
    // ****************************************
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            mp_rx_r <= STAT_RESET[B_MP_RX];
        else if (i_lp_mode)
            mp_rx_r <= STAT_RESET[B_MP_RX];
        else if (mp_rx_take)
            mp_rx_r <= i_rx_char.mp_bit; // [R17] [R3]
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            mp_tx_r <= STAT_RESET[B_MP_TX];
        else if (i_lp_mode)
            mp_tx_r <= STAT_RESET[B_MP_TX];
        else if (i_stat_acc.wr)
            mp_tx_r <= i_stat_acc.wdata[B_MP_TX];
    end
    // Meaningless outside async multiprocessor transmit
    assign o_tx_mp_bit = mp_tx_r && i_async && i_mp_enable; // [R18]

    // ****************************************
    // Holding buffers
    // ****************************************
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            rx_buf_r <= '0;
        else if (rx_take && !rx_full)
            rx_buf_r <= i_rx_char.data; // [R7] [R8] [R11] [R13]
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            tx_buf_r <= '0;
        else if (i_tx_buf_wr)
            tx_buf_r <= i_tx_buf_wdata;
    end

    assign o_rx_holding_buffer = rx_buf_r;
    assign o_tx_holding_buffer = tx_buf_r;

    // ****************************************
    // Readback and interrupts
    // ****************************************
    always_comb
    begin
        o_stat_rdata = '0;
        o_stat_rdata[B_TX_EMPTY] = tx_empty;
        o_stat_rdata[B_RX_FULL] = rx_full;
        o_stat_rdata[B_OVERRUN] = overrun;
        o_stat_rdata[B_FRAMING] = framing;
        o_stat_rdata[B_PARITY] = parity;
        o_stat_rdata[B_TX_DONE] = tx_done_r;
        o_stat_rdata[B_MP_RX] = mp_rx_r;
        o_stat_rdata[B_MP_TX] = mp_tx_r;
    end

    assign o_irq.tx_empty = tx_empty && i_tx_irq_enable; // [R19]
    assign o_irq.rx_full = rx_full && i_rx_irq_enable; // [R20]
    assign o_irq.rx_error = err_any && i_rx_irq_enable; // [R20]
    assign o_irq.tx_done = tx_done_r && i_tx_done_irq_enable; // [R21]
endmodule

//--- rtl/serial_status_pkg.sv
// Purpose: Shared constants and types for the serial status flag block
// Assumes: One system clock, active-low asynchronous reset
// Notes: Bit positions and reset value of the status register
package serial_status_pkg;
    localparam int STAT_W = 8;
    localparam logic [7:0] STAT_RESET = 8'h84;
    localparam int B_TX_EMPTY = 7;
    localparam int B_RX_FULL = 6;
    localparam int B_OVERRUN = 5;
    localparam int B_FRAMING = 4;
    localparam int B_PARITY = 3;
    localparam int B_TX_DONE = 2;
    localparam int B_MP_RX = 1;
    localparam int B_MP_TX = 0;
    localparam int DATA_W = 8;

    // Receive completion event from the receive shifter
    typedef struct packed {
        logic done;
        logic [7:0] data;
        logic parity_bit;
        logic stop_bit;
        logic mp_bit;
    } rx_char_t;

    // CPU access to the status register
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } cpu_acc_t;

    // Interrupt requests
    typedef struct packed {
        logic tx_empty;
        logic rx_full;
        logic rx_error;
        logic tx_done;
    } irq_t;
endpackage

//--- rtl/clear_by_write_flag.sv
// Purpose: One sticky flag cleared by software read-1 then write-0
// Assumes: Set and extra clear events come from the same clock
// Notes: Set wins over any clear in the same cycle
`timescale 1ns/100ps
module clear_by_write_flag #(
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_lp_reset,
    // Events
    input wire logic i_set,
    input wire logic i_hw_clr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic i_wbit,
    // State
    output logic o_flag
);
    logic flag_r;
    logic armed_r;
    logic sw_clr;

    assign sw_clr = i_wr && !i_wbit && armed_r && flag_r; // [R2] [R22]
    assign o_flag = flag_r;

    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            flag_r <= RESET_VAL;
        else if (i_lp_reset)
            flag_r <= RESET_VAL;
        else if (i_set)
            flag_r <= 1'b1; // [R22]
        else if (sw_clr || i_hw_clr)
            flag_r <= 1'b0;
    end

    // Record a read of 1; any write consumes the record
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            armed_r <= 1'b0;
        else if (i_lp_reset || i_wr || !flag_r)
            armed_r <= 1'b0;
        else if (i_rd)
            armed_r <= 1'b1; // [R22]
    end
endmodule

//--- rtl/rx_char_check.sv
// Purpose: Error checks on a completed received character
// Assumes: Stop and parity bits already sampled by the shifter
// Notes: Purely combinational
`timescale 1ns/100ps
module rx_char_check
    import serial_status_pkg::*;
(
    // Character
    input wire rx_char_t i_char,
    // Format
    input wire logic i_async,
    input wire logic i_parity_en,
    input wire logic i_parity_odd_select,
    // Results
    output logic o_framing,
    output logic o_parity
);
    // Only the first stop bit is looked at
    assign o_framing = i_char.done && i_async && !i_char.stop_bit; // [R10]
    // Odd select wants an odd count of ones over data plus parity
    assign o_parity = i_char.done && i_async && i_parity_en &&
        ((^{i_char.data, i_char.parity_bit}) != i_parity_odd_select); // [R13]
endmodule

//--- tb/serial_status_props.sv
// Purpose: Port-level checks of the serial status flags
// Assumes: One clock, reset active low
// Notes: Sees only top ports; bound from the bench top file
`timescale 1ns/100ps
module serial_status_props
    import serial_status_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_lp_mode,
    // Observed ports
    input wire cpu_acc_t i_stat_acc,
    input wire logic [STAT_W-1:0] o_stat_rdata,
    input wire logic i_tx_buf_wr,
    input wire logic i_rx_buf_rd,
    input wire logic [DATA_W-1:0] o_rx_holding_buffer,
    input wire logic i_transmit_enable,
    input wire logic i_rx_on,
    input wire logic i_async,
    input wire logic i_parity_en,
    input wire logic i_parity_odd_select,
    input wire logic i_tx_load,
    input wire logic i_tx_last_bit,
    input wire rx_char_t i_rx_char,
    input wire logic o_rx_allowed
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    // ****************************************
    // Helper terms
    // ****************************************
    logic quiet;
    logic clean;
    logic take;
    // No strobe that could move a flag by itself
    assign quiet = !i_rx_char.done && !i_tx_load && !i_tx_last_bit &&
        !i_tx_buf_wr && !i_rx_buf_rd && !i_lp_mode && i_transmit_enable;
    assign clean = !i_async || (i_rx_char.stop_bit && (!i_parity_en ||
        (^{i_rx_char.data, i_rx_char.parity_bit}) == i_parity_odd_select));
    assign take = i_rx_char.done && o_rx_allowed && !i_rx_buf_rd &&
        !i_lp_mode;
    property p_lp_reload;
        i_lp_mode |=> o_stat_rdata == STAT_RESET;
    endproperty
    a_lp_reload: assert property (p_lp_reload)
        else $error("status not reloaded in low power");
    property p_wr_ones;
        i_stat_acc.wr && (&i_stat_acc.wdata[7:3]) && quiet |=>
            o_stat_rdata[7:1] == $past(o_stat_rdata[7:1]) &&
            o_stat_rdata[0] == $past(i_stat_acc.wdata[0]);
    endproperty
    a_wr_ones: assert property (p_wr_ones)
        else $error("write of ones moved a flag");
    property p_te_off;
        !i_transmit_enable |=> o_stat_rdata[7] && o_stat_rdata[2];
    endproperty
    a_te_off: assert property (p_te_off)
        else $error("tx flags not set with transmit off");
    property p_tx_wr;
        i_tx_buf_wr && !i_tx_load && !i_tx_last_bit && i_transmit_enable &&
            !i_lp_mode |=> !o_stat_rdata[7] && !o_stat_rdata[2];
    endproperty
    a_tx_wr: assert property (p_tx_wr)
        else $error("tx flags not cleared by buffer write");
    property p_rx_clean;
        take && clean && !o_stat_rdata[6] |=> o_stat_rdata[6] &&
            o_rx_holding_buffer == $past(i_rx_char.data);
    endproperty
    a_rx_clean: assert property (p_rx_clean)
        else $error("clean character not stored");
    property p_overrun;
        take && o_stat_rdata[6] |=> o_stat_rdata[5] &&
            $stable(o_rx_holding_buffer);
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not flagged or buffer lost");
    property p_framing;
        take && i_async && !i_rx_char.stop_bit && !o_stat_rdata[6] |=>
            o_stat_rdata[4] && !o_stat_rdata[6] &&
            o_rx_holding_buffer == $past(i_rx_char.data);
    endproperty
    a_framing: assert property (p_framing)
        else $error("framing error handled wrongly");
    property p_allow;
        o_rx_allowed == (i_rx_on && o_stat_rdata[5:3] == 3'h0);
    endproperty
    a_allow: assert property (p_allow)
        else $error("receive allowed with an error flag");
endmodule

//--- tb/serial_station_model.sv
// Purpose: Remote station handing finished characters to the block
// Assumes: Each character arrives as a one-cycle completion strobe
// Notes: Idle fields carry inverted data so stale values never match
`timescale 1ns/100ps
module serial_station_model
    import serial_status_pkg::*;
(
    input wire logic i_ref_clk,
    output rx_char_t o_char
);
    initial o_char = '0;
    // Only the first stop bit is presented; a second is never seen
    task automatic send(logic [7:0] d, logic p, logic s, logic m);
        @(posedge i_ref_clk);
        o_char <= '{1'b1, d, p, s, m};
        @(posedge i_ref_clk);
        o_char <= '{1'b0, ~d, ~p, ~s, ~m};
    endtask
endmodule

//--- tb/serial_status_flags_bench.sv
// Purpose: Self-checking bench for the serial status flags
// Assumes: Strobes are driven one cycle at the rising edge
// Notes: Expected status values follow the flag rules step by step
`timescale 1ns/100ps
module serial_status_flags_bench
    import serial_status_pkg::*;
;
    logic ref_clk = 1'b0, rstn = 1'b0, lp = 1'b0, tx_wr = 1'b0;
    logic te = 1'b1, rx_on = 1'b1, async_m = 1'b1, mp_en = 1'b0;
    logic odd_sel = 1'b0, tx_mp, tx_ok, rx_ok;
    logic par_en = 1'b1;
    logic [2:0] ien = 3'h7;
    irq_t irq;
    logic [2:0] stb = 3'h0;
    logic [7:0] wdat = 8'h00, stat, rx_buf, tx_buf;
    cpu_acc_t acc = '0;
    rx_char_t rx_char;
    int miscompares = 0;
    int total_checks = 0;
    serial_status_flags u_serial_status_flags (
        .i_ref_clk(ref_clk), .i_rstn(rstn), .i_lp_mode(lp),
        .i_stat_acc(acc), .o_stat_rdata(stat), .i_tx_buf_wr(tx_wr),
        .i_tx_buf_wdata(wdat), .i_rx_buf_rd(stb[0]),
        .o_rx_holding_buffer(rx_buf), .i_transmit_enable(te),
        .i_rx_on(rx_on), .i_async(async_m), .i_mp_enable(mp_en),
        .i_parity_en(par_en), .i_parity_odd_select(odd_sel),
        .i_tx_irq_enable(ien[2]), .i_rx_irq_enable(ien[1]),
        .i_tx_done_irq_enable(ien[0]), .i_tx_load(stb[2]),
        .i_tx_last_bit(stb[1]), .o_tx_holding_buffer(tx_buf),
        .o_tx_mp_bit(tx_mp), .o_tx_allowed(tx_ok), .i_rx_char(rx_char),
        .o_rx_allowed(rx_ok), .o_irq(irq));
    serial_station_model u_serial_station_model (
        .i_ref_clk(ref_clk), .o_char(rx_char));
    initial forever #4 ref_clk = ~ref_clk;
    // ****************************************
    // Access tasks
    // ****************************************
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cs(logic [7:0] e);
        #1;
        chk("status", e, stat);
    endtask
    task automatic acc_op(logic r, logic [7:0] d);
        @(posedge ref_clk);
        acc <= '{r, ~r, d};
        @(posedge ref_clk);
        acc <= '{1'b0, 1'b0, d};
    endtask
    task automatic pulse(logic [2:0] v);
        @(posedge ref_clk);
        stb <= v;
        @(posedge ref_clk);
        stb <= 3'h0;
    endtask
    task automatic rx(logic [7:0] d, logic p, logic s, logic m);
        u_serial_station_model.send(d, p, s, m);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        cs(8'h84);
        chk("rx buffer", 8'h00, rx_buf);
        chk("irq", 8'h09, {4'h0, irq});
        acc_op(1'b0, 8'h00);
        cs(8'h84);
        acc_op(1'b0, 8'hFF);
        cs(8'h85);
        chk("mp out", 8'h00, {7'h00, tx_mp});
        @(posedge ref_clk) mp_en <= 1'b1;
        @(posedge ref_clk);
        #1 chk("mp out", 8'h01, {7'h00, tx_mp});
        acc_op(1'b1, 8'h00);
        acc_op(1'b0, 8'h7F);
        cs(8'h01);
        $display("test clear done");
        pulse(3'h4);
        cs(8'h81);
        pulse(3'h2);
        cs(8'h85);
        @(posedge ref_clk) wdat <= 8'h3C;
        tx_wr <= 1'b1;
        @(posedge ref_clk) tx_wr <= 1'b0;
        cs(8'h01);
        chk("tx buffer", 8'h3C, tx_buf);
        @(posedge ref_clk) te <= 1'b0;
        @(posedge ref_clk) te <= 1'b1;
        cs(8'h85);
        $display("test transmit done");
        rx(8'hA5, 1'b0, 1'b1, 1'b0);
        cs(8'hC5);
        rx(8'h3C, 1'b0, 1'b1, 1'b0);
        cs(8'hE5);
        chk("rx allowed", 8'h00, {7'h00, rx_ok});
        chk("irq", 8'h0F, {4'h0, irq});
        @(posedge ref_clk) ien <= 3'h0;
        @(posedge ref_clk);
        #1 chk("irq off", 8'h00, {4'h0, irq});
        @(posedge ref_clk) ien <= 3'h7;
        rx(8'h0F, 1'b0, 1'b1, 1'b0);
        #1 chk("rx buffer", 8'hA5, rx_buf);
        pulse(3'h1);
        cs(8'hA5);
        acc_op(1'b1, 8'h00);
        acc_op(1'b0, 8'hDF);
        cs(8'h85);
        rx(8'h5A, 1'b0, 1'b0, 1'b0);
        cs(8'h95);
        chk("rx buffer", 8'h5A, rx_buf);
        @(posedge ref_clk) async_m <= 1'b0;
        @(posedge ref_clk);
        #1 chk("tx allowed", 8'h00, {7'h00, tx_ok});
        @(posedge ref_clk) async_m <= 1'b1;
        acc_op(1'b1, 8'h00);
        acc_op(1'b0, 8'hEF);
        rx(8'h01, 1'b0, 1'b1, 1'b0);
        cs(8'h8D);
        @(posedge ref_clk) rx_on <= 1'b0;
        rx(8'h77, 1'b0, 1'b1, 1'b1);
        cs(8'h8D);
        chk("rx buffer", 8'h01, rx_buf);
        @(posedge ref_clk) rx_on <= 1'b1;
        acc_op(1'b1, 8'h00);
        acc_op(1'b0, 8'hF7);
        @(posedge ref_clk) odd_sel <= 1'b1;
        rx(8'h80, 1'b0, 1'b1, 1'b1);
        cs(8'hC7);
        pulse(3'h1);
        @(posedge ref_clk) rx_on <= 1'b0;
        rx(8'h80, 1'b0, 1'b1, 1'b0);
        cs(8'h87);
        @(posedge ref_clk) rx_on <= 1'b1;
        par_en <= 1'b0;
        rx(8'h03, 1'b0, 1'b1, 1'b0);
        cs(8'hC5);
        chk("rx buffer", 8'h03, rx_buf);
        $display("test receive done");
        @(posedge ref_clk) lp <= 1'b1;
        @(posedge ref_clk) lp <= 1'b0;
        cs(8'h84);
        $display("test low power done");
        summarize();
    end
    // Whole sequence needs about 70 cycles
    initial
    begin
        repeat (2000) @(posedge ref_clk);
        miscompares++;
        summarize();
    end
endmodule
bind serial_status_flags serial_status_props u_serial_status_props (
    .i_ref_clk, .i_rstn, .i_lp_mode, .i_stat_acc, .o_stat_rdata,
    .i_tx_buf_wr, .i_rx_buf_rd, .o_rx_holding_buffer, .i_transmit_enable,
    .i_rx_on, .i_async, .i_parity_en, .i_parity_odd_select, .i_tx_load,
    .i_tx_last_bit, .i_rx_char, .o_rx_allowed);
